// ==== dv/smbsra_host_model.sv ====
`timescale 1ns/1ps
// ==========================================================
// Bus master model that clocks the slave
// ==========================================================
module smbsra_host_model (
    input  wire logic clk,      // Core clock that paces the link.
    input  wire logic sda_wire, // Resolved data line level.
    output logic      scl,      // Clock line, high while idle.
    output logic      sda_drv   // Data drive, high means released.
);
    // Half of the 160 ns link period in core cycles; a larger value makes a slow master.
    int half = 8;

    // The clock idles high and only moves inside frames.
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // One bit: data moves mid low phase, so it never changes while the clock is high.
    task automatic pulse(input logic d, output logic r, output logic f);
        tick(1);
        scl <= 1'b0;
        tick(half / 2);
        sda_drv <= d;
        tick(half - half / 2);
        scl <= 1'b1;
        @(negedge clk);
        r = sda_wire;
        repeat (half - 1) @(negedge clk);
        f = sda_wire;
    endtask

    // Start from idle or repeated start from a low clock.
    task automatic start();
        tick(1);
        scl <= 1'b0;
        tick(half / 2);
        sda_drv <= 1'b1;
        tick(half);
        scl <= 1'b1;
        tick(half);
        sda_drv <= 1'b0;
        tick(half);
    endtask

    // Stop, then bus free time before anything else.
    task automatic stop();
        tick(1);
        scl <= 1'b0;
        tick(half / 2);
        sda_drv <= 1'b0;
        tick(half);
        scl <= 1'b1;
        tick(half);
        sda_drv <= 1'b1;
        tick(2 * half);
    endtask

    // Eight bits most significant first, then the line is released for the answer.
    task automatic send(input logic [7:0] b, output logic ack);
        logic r;
        logic f;
        for (int i = 7; i >= 0; i--) pulse(b[i], r, f);
        pulse(1'b1, r, f);
        ack = !r && !f;
    endtask

    // Reads a byte; the last one is refused so the slave lets go.
    task automatic recv(input logic last, output logic [7:0] b);
        logic r;
        logic f;
        for (int i = 7; i >= 0; i--) begin
            pulse(1'b1, r, f);
            b[i] = f;
        end
        pulse(last, r, f);
    endtask

    // Holds the clock low, as a master does to recover a hung bus.
    task automatic hold_low(input int n);
        tick(1);
        scl <= 1'b0;
        tick(n);
    endtask
endmodule

// ==== dv/tb_smbus_slave_register_access.sv ====
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the slave register access block
// ==========================================================
module tb_smbus_slave_register_access;
    // A short bus timeout keeps the run brief.
    localparam int TO_CYC = 2000;

    typedef struct packed {
        logic [7:0] ptr;
        logic [7:0] data;
        logic       ok;
        logic [7:0] half;
    } smbsra_row_t;

    logic        core_clk, rst_n, scl, sda_drv, sda_wire, sda_o, sda_oe;
    logic        strap_en, strap_sel, strap_wire, fan_pwm_req, pwm_o, pwm_oe;
    logic        tach, strap_done, reg_ptr_valid, reg_wr, reg_rd;
    logic [7:0]  reg_ptr, reg_wdata, reg_rdata, d;
    logic [2:0]  k;
    logic [7:0]  mem [256];
    int          errors, num_checks, wr_count, rd_count;
    smbsra_row_t rows [4] = '{'{8'h04, 8'h3C, 1'b1, 8'h08}, '{8'h09, 8'hC3, 1'b1, 8'h08},
                              '{8'h2F, 8'h81, 1'b1, 8'h18}, '{8'h30, 8'h55, 1'b0, 8'h08}};
    logic [8:0]  cfg [2] = '{{1'b1, 1'b0, 7'h2E}, {1'b0, 1'b1, 7'h2D}};

    // Open-drain lines with pull-ups; registers 00h to 2Fh exist.
    assign sda_wire      = sda_drv & ~sda_oe;
    assign strap_wire    = strap_en & ~pwm_oe;
    assign reg_ptr_valid = reg_ptr < 8'h30;
    assign reg_rdata     = mem[reg_ptr];

    // Register file behind the block.
    always @(posedge core_clk) begin
        if (reg_wr === 1'b1) begin
            mem[reg_ptr] <= reg_wdata;
            wr_count++;
        end
        if (reg_rd === 1'b1) begin
            rd_count++;
        end
    end

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    smbsra_top #(.TIMEOUT_CYC(TO_CYC)) smbsra_top_inst (
        .core_clk            (core_clk),
        .rst_n               (rst_n),
        .serial_clock_pin    (scl),
        .serial_data_i       (sda_wire),
        .serial_data_o       (sda_o),
        .serial_data_oe      (sda_oe),
        .addr_strap_enable_i (strap_wire),
        .fan_pwm_out_three_o (pwm_o),
        .fan_pwm_out_three_oe(pwm_oe),
        .fan_speed_in_four   (strap_sel),
        .fan_pwm_req         (fan_pwm_req),
        .fan_tach_four       (tach),
        .strap_done          (strap_done),
        .reg_ptr             (reg_ptr),
        .reg_ptr_valid       (reg_ptr_valid),
        .reg_wr              (reg_wr),
        .reg_wdata           (reg_wdata),
        .reg_rdata           (reg_rdata),
        .reg_rd              (reg_rd)
    );

    smbsra_host_model smbsra_host_model_inst (
        .clk     (core_clk),
        .sda_wire(sda_wire),
        .scl     (scl),
        .sda_drv (sda_drv)
    );

    task automatic check_bit(input string what, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Write transfer; every write opens with a pointer byte.
    task automatic wr1(input logic [6:0] a, input logic [7:0] p, input logic [7:0] v);
        smbsra_host_model_inst.start();
        smbsra_host_model_inst.send({a, 1'b0}, k[2]);
        smbsra_host_model_inst.send(p, k[1]);
        smbsra_host_model_inst.send(v, k[0]);
        smbsra_host_model_inst.stop();
    endtask

    // Read transfer, optionally after a pointer set and a repeated start.
    task automatic rd1(input logic [6:0] a, input logic set, input logic [7:0] p);
        logic ack;
        smbsra_host_model_inst.start();
        if (set) begin
            smbsra_host_model_inst.send({a, 1'b0}, ack);
            smbsra_host_model_inst.send(p, ack);
            smbsra_host_model_inst.start();
        end
        smbsra_host_model_inst.send({a, 1'b1}, ack);
        smbsra_host_model_inst.recv(1'b1, d);
        smbsra_host_model_inst.stop();
    endtask

    // Watchdog sized well above the expected run of about 14000 cycles.
    initial begin
        repeat (60000) @(posedge core_clk);
        errors++;
        close_out();
    end

    // Main sequence: table rows first, then the awkward cases.
    initial begin
        rst_n = 1'b0;
        strap_en = 1'b0;
        strap_sel = 1'b0;
        fan_pwm_req = 1'b0;
        errors = 0;
        num_checks = 0;
        wr_count = 0;
        for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (10) @(posedge core_clk);
        check_bit("pwm oe in strap phase", 1'b0, pwm_oe);
        foreach (rows[i]) begin
            smbsra_host_model_inst.half = int'(rows[i].half);
            wr1(7'h2C, rows[i].ptr, rows[i].data);
            check_byte("write acks", {5'h00, 2'b11, rows[i].ok}, {5'h00, k});
            check_byte("pointer", rows[i].ptr, reg_ptr);
            check_byte("stored", rows[i].ok ? rows[i].data : rows[i].ptr ^ 8'h5A,
                       mem[rows[i].ptr]);
            rd1(7'h2C, 1'b1, rows[i].ptr);
            check_byte("read", rows[i].ok ? rows[i].data : 8'hFF, d);
            $display("test row %0d done", i);
        end
        smbsra_host_model_inst.half = 8;
        // Strap pins take their normal roles; the address stays locked.
        check_bit("strap done", 1'b1, strap_done);
        strap_sel <= 1'b1;
        repeat (8) @(posedge core_clk);
        @(negedge core_clk);
        check_bit("tach follows pin", 1'b1, tach);
        check_bit("pwm drives low", 1'b1, pwm_oe);
        @(posedge core_clk);
        fan_pwm_req <= 1'b1;
        @(negedge core_clk);
        check_bit("pwm released high", 1'b0, pwm_oe);
        @(posedge core_clk);
        fan_pwm_req <= 1'b0;
        wr1(7'h2D, 8'h04, 8'h11);
        check_byte("locked address", 8'h00, {5'h00, k});
        // Two data bytes land in one register without a stride.
        wr_count = 0;
        rd_count = 0;
        smbsra_host_model_inst.start();
        smbsra_host_model_inst.send(8'h58, k[2]);
        smbsra_host_model_inst.send(8'h05, k[2]);
        smbsra_host_model_inst.send(8'hE1, k[1]);
        smbsra_host_model_inst.send(8'h6B, k[0]);
        smbsra_host_model_inst.stop();
        check_byte("two byte acks", 8'h07, {5'h00, k});
        check_byte("write count", 8'h02, 8'(wr_count));
        rd1(7'h2C, 1'b0, 8'h00);
        check_byte("kept pointer read", 8'h6B, d);
        check_byte("read fetches", 8'h01, 8'(rd_count));
        $display("test lock and two bytes done");
        // Clock held low in mid read: the slave must let go and recover.
        smbsra_host_model_inst.start();
        smbsra_host_model_inst.send(8'h59, k[0]);
        smbsra_host_model_inst.hold_low(20);
        check_bit("first bit driven", 1'b1, sda_oe);
        smbsra_host_model_inst.hold_low(TO_CYC + 100);
        check_bit("released on timeout", 1'b0, sda_oe);
        rd1(7'h2C, 1'b1, 8'h04);
        check_byte("read after timeout", 8'h3C, d);
        $display("test timeout done");
        // Reset in mid run with other strap settings.
        foreach (cfg[j]) begin
            @(posedge core_clk);
            rst_n <= 1'b0;
            strap_en <= cfg[j][8];
            strap_sel <= cfg[j][7];
            repeat (2) @(posedge core_clk);
            @(negedge core_clk);
            check_byte("pointer in reset", 8'h00, reg_ptr);
            check_bit("strap done in reset", 1'b0, strap_done);
            check_bit("sda oe in reset", 1'b0, sda_oe);
            @(posedge core_clk);
            rst_n <= 1'b1;
            repeat (10) @(posedge core_clk);
            wr1(7'h2C, 8'h09, 8'h77);
            check_byte("other address", 8'h00, {5'h00, k});
            check_bit("no lock on miss", 1'b0, strap_done);
            rd1(cfg[j][6:0], 1'b1, 8'h09);
            check_byte("strap address read", 8'hC3, d);
            check_bit("lock after stop", 1'b1, strap_done);
            $display("test strap config %0d done", j);
        end
        check_bit("sda drive value", 1'b0, sda_o);
        check_bit("pwm drive value", 1'b0, pwm_o);
        close_out();
    end
endmodule

// ==== rtl/smbsra_pkg.sv ====
// Contract
// - Device is slave only; master clocks SCL.
// - Nine clocks per byte, no gaps.
// - SDA changes only while SCL low.
// - Detect start and stop conditions.
// - Acknowledge every addressed byte, whole ninth clock.
// - Enable pin is open-drain input at power-on.
// - Enable strap high gives default address.
// - Straps select 2Ch, 2Dh or 2Eh.
// - Latch address on first prefix-matching transaction; code latches only when the address also equals the strap-selected address.
// - Strap pins revert after first transaction.
// - Acknowledge address only when it matches.
// - Support one or two data bytes.
// - First write byte loads the pointer, acknowledged.
// - Invalid pointer abandons the operation.
// - Pointer keeps its value between transactions.
// - Store write bytes, stop ends write.
// - Without repeated start, bytes are write data.
// - Read data starts next clock, MSB first.
// - Timeout returns state machine to idle.
// - SCL low 25 to 35 ms releases SDA.
package smbsra_pkg;

    // ==========================================================
    // Addressing and timing
    // ==========================================================
    localparam logic [4:0] ADDR_PREFIX     = 5'h0B;   // 0 1011b
    localparam logic [6:0] ADDR_EN_LO_SEL0 = 7'h2C;
    localparam logic [6:0] ADDR_EN_LO_SEL1 = 7'h2D;
    localparam logic [6:0] ADDR_DEFAULT    = 7'h2E;
    localparam int         CLK_MHZ         = 100;
    localparam int         TIMEOUT_MIN_MS  = 25;
    localparam int         TIMEOUT_MAX_MS  = 35;
    // Fire at 30 ms, inside the window.
    localparam int         TIMEOUT_MS      = (TIMEOUT_MIN_MS + TIMEOUT_MAX_MS) / 2;
    localparam int         TIMEOUT_CYC     = TIMEOUT_MS * 1000 * CLK_MHZ;
    localparam int         BITS_PER_BYTE   = 8;
    localparam logic [3:0] ACK_SLOT        = 4'h8;    // Ninth clock, index 8.
    localparam logic [7:0] PTR_RESET       = 8'h00;

    typedef enum logic [5:0] {
        SMBSRA_IDLE = 6'b000001,
        SMBSRA_ADDR = 6'b000010,
        SMBSRA_PTR  = 6'b000100,
        SMBSRA_WDAT = 6'b001000,
        SMBSRA_RDAT = 6'b010000,
        SMBSRA_IGN  = 6'b100000
    } smbsra_state_t;

endpackage

// ==== rtl/smbsra_sync.sv ====
`timescale 1ns/1ps
// ==========================================================
// Three-stage pin synchroniser with agreement filter
// ==========================================================
module smbsra_sync (
    input  wire logic clk,      // Core clock.
    input  wire logic rst_n,    // Synchronised reset, active low.
    input  wire logic din,      // Asynchronous pin level.
    output logic      dout      // Filtered level.
);
    logic s1;
    logic s2;
    logic s3;

    // A change counts only once the second and third stages agree.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1   <= 1'b1;
            s2   <= 1'b1;
            s3   <= 1'b1;
            dout <= 1'b1;
        end else begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                dout <= s3;
            end
        end
    end
endmodule

// ==== rtl/smbsra_top.sv ====
`timescale 1ns/1ps
// ==========================================================
// SMBus slave with pointer-based register access
// ==========================================================
module smbsra_top #(
    parameter int TIMEOUT_CYC = smbsra_pkg::TIMEOUT_CYC  // Bus timeout in cycles.
) (
    input  wire logic       core_clk,        // 100 MHz core clock.
    input  wire logic       rst_n,           // Asynchronous reset, active low.
    input  wire logic       serial_clock_pin,// SCL level from the bus.
    input  wire logic       serial_data_i,   // SDA level from the bus.
    output logic            serial_data_o,   // SDA drive value, always zero.
    output logic            serial_data_oe,  // SDA pull-low enable.
    input  wire logic       addr_strap_enable_i, // Enable strap / PWM pin level.
    output logic            fan_pwm_out_three_o, // PWM drive value, always zero.
    output logic            fan_pwm_out_three_oe,// PWM pull-low enable.
    input  wire logic       fan_speed_in_four,   // Select strap / tach pin.
    input  wire logic       fan_pwm_req,     // Fan PWM level from fan control.
    output logic            fan_tach_four,   // Tach level to fan logic.
    output logic            strap_done,      // Strap phase over, pins normal.
    output logic [7:0]      reg_ptr,         // Register pointer.
    input  wire logic       reg_ptr_valid,   // Pointer names a register.
    output logic            reg_wr,          // Write strobe, one cycle.
    output logic [7:0]      reg_wdata,       // Write data.
    input  wire logic [7:0] reg_rdata,       // Read data at pointer.
    output logic            reg_rd           // Read byte fetched, one cycle.
);
    // ==========================================================
    // Reset release and input sampling
    // ==========================================================
    logic rst_m;
    logic rst_s;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_m <= 1'b0;
            rst_s <= 1'b0;
        end else begin
            rst_m <= 1'b1;
            rst_s <= rst_m;
        end
    end

    logic scl;
    logic sda;
    logic strap_en;
    logic strap_sel;
    smbsra_sync u_scl (.clk(core_clk), .rst_n(rst_s), .din(serial_clock_pin), .dout(scl));
    smbsra_sync u_sda (.clk(core_clk), .rst_n(rst_s), .din(serial_data_i), .dout(sda));
    smbsra_sync u_aen (.clk(core_clk), .rst_n(rst_s), .din(addr_strap_enable_i),
                       .dout(strap_en));
    smbsra_sync u_sel (.clk(core_clk), .rst_n(rst_s), .din(fan_speed_in_four),
                       .dout(strap_sel));

    logic scl_q;
    logic sda_q;
    always_ff @(posedge core_clk or negedge rst_s) begin
        if (!rst_s) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
        end
    end

    // Edges and bus conditions; the master alone makes them.
    wire scl_rise = scl & ~scl_q;
    wire scl_fall = ~scl & scl_q;
    wire start_c  = scl & scl_q & sda_q & ~sda;
    wire stop_c   = scl & scl_q & ~sda_q & sda;

    // ==========================================================
    // Bus timeout counter
    // ==========================================================
    logic [31:0] to_cnt;
    logic        timeout;
    // SCL held low for TIMEOUT_CYC cycles, inside the window, resets the interface.
    always_ff @(posedge core_clk or negedge rst_s) begin
        if (!rst_s) begin
            to_cnt  <= 32'h0000_0000;
            timeout <= 1'b0;
        end else begin
            timeout <= 1'b0;
            if (scl) begin
                to_cnt <= 32'h0000_0000;
            end else if (to_cnt == 32'(TIMEOUT_CYC - 1)) begin
                to_cnt  <= 32'h0000_0000;
                timeout <= 1'b1;
            end else begin
                to_cnt <= to_cnt + 32'h0000_0001;
            end
        end
    end

    // ==========================================================
    // Address selection from straps
    // ==========================================================
    // The strap level is caught by the clock, never by the reset.
    wire [6:0] strap_addr = strap_en  ? smbsra_pkg::ADDR_DEFAULT :
                            strap_sel ? smbsra_pkg::ADDR_EN_LO_SEL1 :
                                        smbsra_pkg::ADDR_EN_LO_SEL0;
    logic       addr_locked;
    logic [6:0] own_addr;
    wire  [6:0] cur_addr = addr_locked ? own_addr : strap_addr;

    // ==========================================================
    // Serial state machine
    // ==========================================================
    smbsra_pkg::smbsra_state_t state;
    logic [3:0] bit_idx;
    logic [7:0] shreg;
    logic       rw;
    logic       ack_drive;
    logic       tx_drive;
    logic       first_done;
    logic       in_txn;
    logic       ack_pend;

    wire byte_done  = scl_rise && bit_idx == 4'(smbsra_pkg::BITS_PER_BYTE - 1);
    wire in_ack     = bit_idx == smbsra_pkg::ACK_SLOT;
    wire [7:0] rx_byte = {shreg[6:0], sda};
    wire addr_hit   = rx_byte[7:1] == cur_addr;
    wire pfx_hit    = rx_byte[7:3] == smbsra_pkg::ADDR_PREFIX;

    // Byte framing: eight data clocks then one acknowledge clock.
    always_ff @(posedge core_clk or negedge rst_s) begin
        if (!rst_s) begin
            state       <= smbsra_pkg::SMBSRA_IDLE;
            bit_idx     <= 4'h0;
            shreg       <= 8'h00;
            rw          <= 1'b0;
            ack_drive   <= 1'b0;
            tx_drive    <= 1'b0;
            reg_ptr     <= smbsra_pkg::PTR_RESET;
            reg_wr      <= 1'b0;
            reg_rd      <= 1'b0;
            reg_wdata   <= 8'h00;
            addr_locked <= 1'b0;
            own_addr    <= smbsra_pkg::ADDR_DEFAULT;
            first_done  <= 1'b0;
            in_txn      <= 1'b0;
            ack_pend    <= 1'b0;
        end else begin
            reg_wr <= 1'b0;
            reg_rd <= 1'b0;
            if (timeout) begin
                state     <= smbsra_pkg::SMBSRA_IDLE;
                ack_drive <= 1'b0;
                ack_pend  <= 1'b0;
                tx_drive  <= 1'b0;
                in_txn    <= 1'b0;
            end else if (start_c) begin
                state     <= smbsra_pkg::SMBSRA_ADDR;
                ack_pend  <= 1'b0;
                bit_idx   <= 4'h0;
                ack_drive <= 1'b0;
                tx_drive  <= 1'b0;
            end else if (stop_c) begin
                state     <= smbsra_pkg::SMBSRA_IDLE;
                ack_pend  <= 1'b0;
                ack_drive <= 1'b0;
                tx_drive  <= 1'b0;
                if (in_txn) begin
                    first_done <= 1'b1;
                end
                in_txn <= 1'b0;
            end else if (state != smbsra_pkg::SMBSRA_IDLE) begin
                if (scl_rise && !in_ack) begin
                    shreg <= rx_byte;
                end
                if (scl_rise) begin
                    bit_idx <= in_ack ? 4'h0 : bit_idx + 4'h1;
                end
                // Shift read data out on each falling edge, MSB first; the
                // register shifts on every data-clock rise, so its top bit is always next.
                if (scl_fall && state == smbsra_pkg::SMBSRA_RDAT && !in_ack) begin
                    if (bit_idx == 4'h0) begin
                        tx_drive <= ~reg_rdata[7];
                        shreg    <= reg_rdata;
                        reg_rd   <= 1'b1;
                    end else begin
                        tx_drive <= ~shreg[7];
                    end
                end
                // SDA moves only while SCL is low: the acknowledge goes on at the
                // fall after the eighth clock and off at the fall after the ninth.
                if (scl_fall && in_ack) begin
                    ack_drive <= ack_pend;
                    ack_pend  <= 1'b0;
                    tx_drive  <= 1'b0;
                end else if (scl_fall && bit_idx == 4'h0) begin
                    ack_drive <= 1'b0;
                end
                if (byte_done) begin
                    unique case (state)
                        smbsra_pkg::SMBSRA_ADDR: begin
                            if (addr_hit && (addr_locked || pfx_hit)) begin
                                ack_pend    <= 1'b1;
                                rw          <= sda;
                                in_txn      <= 1'b1;
                                addr_locked <= 1'b1;
                                own_addr    <= cur_addr;
                                state       <= sda ? smbsra_pkg::SMBSRA_RDAT
                                                   : smbsra_pkg::SMBSRA_PTR;
                            end else begin
                                state <= smbsra_pkg::SMBSRA_IGN;
                            end
                        end
                        smbsra_pkg::SMBSRA_PTR: begin
                            reg_ptr   <= rx_byte;
                            ack_pend  <= 1'b1;
                            state     <= smbsra_pkg::SMBSRA_WDAT;
                        end
                        smbsra_pkg::SMBSRA_WDAT: begin
                            if (reg_ptr_valid) begin
                                reg_wdata <= rx_byte;
                                reg_wr    <= 1'b1;
                                ack_pend  <= 1'b1;
                            end else begin
                                state <= smbsra_pkg::SMBSRA_IGN;
                            end
                        end
                        smbsra_pkg::SMBSRA_RDAT: begin
                            ack_pend <= 1'b0;                   // The master answers.
                        end
                        smbsra_pkg::SMBSRA_IGN: begin
                        end
                        default: begin
                            state <= smbsra_pkg::SMBSRA_IDLE;
                        end
                    endcase
                end
                // Master NACK ends the read; wait for stop.
                if (scl_rise && in_ack && state == smbsra_pkg::SMBSRA_RDAT && sda) begin
                    state <= smbsra_pkg::SMBSRA_IGN;
                end
                // Invalid pointer abandons a read too.
                if (state == smbsra_pkg::SMBSRA_RDAT && !reg_ptr_valid && !in_ack
                    && bit_idx == 4'h0 && !tx_drive) begin
                    state <= smbsra_pkg::SMBSRA_IGN;
                end
            end
        end
    end

    // ==========================================================
    // Pin drivers
    // ==========================================================
    // SDA is only ever pulled low or released.
    assign serial_data_o        = 1'b0;
    assign serial_data_oe       = ack_drive | tx_drive;
    assign strap_done           = first_done;
    // Strap pins are inputs until the first transaction completes.
    assign fan_pwm_out_three_o  = 1'b0;
    assign fan_pwm_out_three_oe = first_done & ~fan_pwm_req;
    assign fan_tach_four        = first_done & strap_sel;

    // ==========================================================
    // Checks
    // ==========================================================
    stop_idle_a: assert property (@(posedge core_clk) disable iff (!rst_s)
        stop_c && !timeout |=> state == smbsra_pkg::SMBSRA_IDLE && !serial_data_oe)
        else $error("stop did not return to idle");
    start_addr_a: assert property (@(posedge core_clk) disable iff (!rst_s)
        start_c && !timeout |=> state == smbsra_pkg::SMBSRA_ADDR && bit_idx == 4'h0)
        else $error("start did not enter address phase");
    timeout_rel_a: assert property (@(posedge core_clk) disable iff (!rst_s)
        timeout |=> !serial_data_oe && state == smbsra_pkg::SMBSRA_IDLE)
        else $error("timeout did not release bus");
    pins_strap_a: assert property (@(posedge core_clk) disable iff (!rst_s)
        !first_done |-> !fan_pwm_out_three_oe)
        else $error("strap pin driven before first transaction");
    lock_keep_a: assert property (@(posedge core_clk) disable iff (!rst_s)
        addr_locked |=> addr_locked && own_addr == $past(own_addr))
        else $error("locked address changed");
    ptr_load_a: assert property (@(posedge core_clk) disable iff (!rst_s)
        byte_done && state == smbsra_pkg::SMBSRA_PTR && !start_c && !stop_c && !timeout
        |=> reg_ptr == $past(rx_byte) && ack_pend)
        else $error("pointer byte not loaded and acknowledged");
    ptr_hold_a: assert property (@(posedge core_clk) disable iff (!rst_s)
        state != smbsra_pkg::SMBSRA_PTR |=> reg_ptr == $past(reg_ptr))
        else $error("pointer changed outside pointer phase");
    addr_miss_a: assert property (@(posedge core_clk) disable iff (!rst_s)
        byte_done && state == smbsra_pkg::SMBSRA_ADDR && !addr_hit && !start_c
        && !stop_c && !timeout |=> !serial_data_oe && !ack_pend)
        else $error("acknowledged foreign address");
    wr_valid_a: assert property (@(posedge core_clk) disable iff (!rst_s)
        reg_wr |-> $past(reg_ptr_valid))
        else $error("write to invalid pointer");
    ack_hold_a: assert property (@(posedge core_clk) disable iff (!rst_s)
        scl_fall && in_ack && ack_pend && !start_c && !stop_c && !timeout |=> serial_data_oe)
        else $error("acknowledge not driven in ninth clock");
    ack_slot_a: assert property (@(posedge core_clk) disable iff (!rst_s)
        ack_drive |-> bit_idx == smbsra_pkg::ACK_SLOT || bit_idx == 4'h0)
        else $error("acknowledge outside its clock");
    sda_lowclk_a: assert property (@(posedge core_clk) disable iff (!rst_s)
        $changed(serial_data_oe) |-> !scl)
        else $error("SDA drive changed while SCL high");
    nack_end_a: assert property (@(posedge core_clk) disable iff (!rst_s)
        scl_rise && in_ack && sda && state == smbsra_pkg::SMBSRA_RDAT
        && !start_c && !stop_c && !timeout |=> state == smbsra_pkg::SMBSRA_IGN)
        else $error("master refusal did not end the read");
endmodule
